// ### common/pga_pkg.sv
// Constants for the port G override and port A-D register block
package pga_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned BANK_W   = 8;
  localparam int unsigned NBANKS   = 4;
  localparam int unsigned PG_W     = 5;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] BANK_STRIDE   = 8'h10;
  localparam logic [7:0] OFF_LATCH     = 8'h00;
  localparam logic [7:0] OFF_DIR       = 8'h04;
  localparam logic [7:0] OFF_SENSE     = 8'h08;
  localparam logic [7:0] ADDR_BANK_A   = 8'h00;
  localparam logic [7:0] ADDR_BANK_B   = 8'h10;
  localparam logic [7:0] ADDR_BANK_C   = 8'h20;
  localparam logic [7:0] ADDR_BANK_D   = 8'h30;
  localparam logic [7:0] ADDR_ALT_CTRL = 8'h40;

  // Address fields
  localparam int unsigned BANK_LSB  = 4;
  localparam int unsigned FIELD_LSB = 2;
  localparam logic [1:0] FLD_LATCH  = 2'h0;
  localparam logic [1:0] FLD_DIR    = 2'h1;
  localparam logic [1:0] FLD_SENSE  = 2'h2;
  localparam logic [1:0] BANK_C_IDX = 2'h2;

  // ==========================================================
  // Alternate-function control register fields
  localparam int unsigned CTRL_ASYNC_BIT = 0;
  localparam int unsigned CTRL_EXTMEM_BIT = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [7:0] LEGACY_C_DIR = 8'hff;
  localparam logic [1:0] CTRL_RST  = 2'h0;

  // ==========================================================
  // Port G pin positions
  localparam int unsigned PG_XIN  = 4;
  localparam int unsigned PG_XOUT = 3;
  localparam int unsigned PG_ALE  = 2;
  localparam int unsigned PG_RD   = 1;
  localparam int unsigned PG_WR   = 0;

endpackage : pga_pkg

// ### dv/pga_pin_env.sv
// Pin-side model of one 8-bit port: outside drivers, pull-ups, floating
`timescale 1ns/1ps
module pga_pin_env
(
  input  wire logic       clk,
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pull_on,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext,
  output wire logic [7:0] lvl
);
  // ==========================================================
  // Pin level
  // Floating pins toggle every cycle, so a stale level never passes
  logic [7:0] float_q;

  initial float_q = 8'h55;

  always @(posedge clk)
    float_q <= ~float_q;

  // Device drive wins where its output enable is low
  assign lvl = (~oe_n & out) | (oe_n & ext_en & ext)
             | (oe_n & ~ext_en & (pull_on | float_q));
endmodule : pga_pin_env

// ### dv/test_port_g_altfunc_and_port_regs.sv
// Self-checking bench for port A-D registers and port G overrides
`timescale 1ns/1ps
module test_port_g_altfunc_and_port_regs;
  // ==========================================================
  // Signals
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  logic        compat_mode;
  wire  [7:0]  po    [0:3];
  wire  [7:0]  poe_n [0:3];
  wire  [7:0]  ppu   [0:3];
  wire  [7:0]  pin   [0:3];
  logic [7:0]  ext_en;
  logic [7:0]  ext;
  logic [4:0]  pg_base_out;
  logic [4:0]  pg_base_dir;
  logic [4:0]  pg_base_pull;
  logic        ale;
  logic        rd_n;
  logic        wr_n;
  wire  [4:0]  pg_out;
  wire  [4:0]  pg_oe_n;
  wire  [4:0]  pg_pullup;
  wire  [4:0]  pg_in_en;
  wire         xtal_amp_en;
  int          total_checks;
  int          n_mismatch;
  int          cycles;

  // ==========================================================
  // Design and pin models
  pga_port_top i_dut
  (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compat_mode(compat_mode),
    .pa_in(pin[0]), .pa_out(po[0]), .pa_oe_n(poe_n[0]), .pa_pullup(ppu[0]),
    .pb_in(pin[1]), .pb_out(po[1]), .pb_oe_n(poe_n[1]), .pb_pullup(ppu[1]),
    .pc_in(pin[2]), .pc_out(po[2]), .pc_oe_n(poe_n[2]), .pc_pullup(ppu[2]),
    .pd_in(pin[3]), .pd_out(po[3]), .pd_oe_n(poe_n[3]), .pd_pullup(ppu[3]),
    .pg_base_out(pg_base_out), .pg_base_dir(pg_base_dir),
    .pg_base_pull(pg_base_pull), .ext_mem_ale(ale),
    .ext_mem_rd_n(rd_n), .ext_mem_wr_n(wr_n), .pg_out(pg_out),
    .pg_oe_n(pg_oe_n), .pg_pullup(pg_pullup), .pg_in_en(pg_in_en),
    .xtal_amp_en(xtal_amp_en)
  );

  for (genvar g = 0; g < 4; g++)
  begin : g_pins
    pga_pin_env i_env
    (
      .clk(clk), .out(po[g]), .oe_n(poe_n[g]), .pull_on(ppu[g]),
      .ext_en(ext_en), .ext(ext), .lvl(pin[g])
    );
  end

  // ==========================================================
  // Clock and hang guard
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] ra(input int i, input logic [7:0] off);
    return 32'(i) * {24'h0, pga_pkg::BANK_STRIDE} + {24'h0, off};
  endfunction : ra

  // No wait count assumed: loop until pready, guard ends a hang
  task automatic apb(input logic wr, input logic [31:0] a, d,
                     input logic [3:0] s, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, {24'h0, d}, 4'hf, rd, err);
    @(negedge clk);
  endtask : wreg

  task automatic rchk(input string nm, input logic [31:0] a, exp,
                      input logic eerr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, 4'hf, rd, err);
    check(nm, rd, exp);
    check({nm, " err"}, {31'h0, err}, {31'h0, eerr});
  endtask : rchk

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      rchk("latch", ra(i, pga_pkg::OFF_LATCH), 32'h0, 1'b0);
      rchk("dir", ra(i, pga_pkg::OFF_DIR), 32'h0, 1'b0);
      check("oe_n", {24'h0, poe_n[i]}, 32'hff);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_rw;
    logic [7:0]  lat;
    logic [7:0]  dir;
    logic [7:0]  m;
    logic [31:0] rd;
    logic        err;
    for (int p = 0; p < 2; p++)
    begin
      ext_en <= p ? 8'hff : 8'h00;
      ext    <= 8'h0f;
      for (int i = 0; i < 4; i++)
      begin
        lat = 8'ha5 ^ 8'(i * 33);
        dir = 8'h5a ^ 8'(i * 19);
        wreg(ra(i, pga_pkg::OFF_LATCH), lat);
        wreg(ra(i, pga_pkg::OFF_DIR), dir);
        // Mask only once the new ext_en has landed
        m   = dir | lat | ext_en;
        check("out", {24'h0, po[i]}, {24'h0, lat});
        check("oe_n", {24'h0, poe_n[i]}, {24'h0, ~dir});
        check("pullup", {24'h0, ppu[i]}, {24'h0, ~dir & lat});
        repeat (3) @(posedge clk);
        rchk("latch rd", ra(i, pga_pkg::OFF_LATCH),
             {24'h0, lat}, 1'b0);
        rchk("dir rd", ra(i, pga_pkg::OFF_DIR), {24'h0, dir}, 1'b0);
        apb(1'b0, ra(i, pga_pkg::OFF_SENSE), 32'h0, 4'hf, rd, err);
        check("sense", rd & {24'h0, m}, {24'h0, m & ((dir & lat)
              | (~dir & ext_en & ext) | (~dir & ~ext_en & lat))});
      end
    end
    apb(1'b1, ra(0, pga_pkg::OFF_SENSE), 32'hff, 4'hf, rd, err);
    check("sense wr err", {31'h0, err}, 32'h0);
    apb(1'b1, ra(0, pga_pkg::OFF_LATCH), 32'h00, 4'he, rd, err);
    rchk("strb off", ra(0, pga_pkg::OFF_LATCH), 32'ha5, 1'b0);
    rchk("unmapped", 32'h44, 32'h0, 1'b1);
    rchk("gap", ra(1, 8'h0c), 32'h0, 1'b1);
    $display("test rw done");
  endtask : t_rw

  task automatic t_pg;
    pg_base_out  <= 5'h15;
    pg_base_dir  <= 5'h0a;
    pg_base_pull <= 5'h1f;
    ale  <= 1'b0;
    rd_n <= 1'b1;
    wr_n <= 1'b0;
    wreg({24'h0, pga_pkg::ADDR_ALT_CTRL}, 8'h01);
    check("g out", {27'h0, pg_out}, 32'h15);
    check("g oe_n", {27'h0, pg_oe_n}, 32'h1d);
    check("g pull", {27'h0, pg_pullup}, 32'h07);
    check("g in_en", {27'h0, pg_in_en}, 32'h07);
    check("xtal", {31'h0, xtal_amp_en}, 32'h1);
    wreg({24'h0, pga_pkg::ADDR_ALT_CTRL}, 8'h02);
    check("g out", {27'h0, pg_out}, 32'h12);
    check("g oe_n", {27'h0, pg_oe_n}, 32'h10);
    check("g pull", {27'h0, pg_pullup}, 32'h18);
    check("g in_en", {27'h0, pg_in_en}, 32'h1f);
    check("xtal", {31'h0, xtal_amp_en}, 32'h0);
    @(posedge clk);
    ale  <= 1'b1;
    rd_n <= 1'b0;
    wr_n <= 1'b1;
    @(negedge clk);
    check("strobes", {27'h0, pg_out}, 32'h15);
    wreg({24'h0, pga_pkg::ADDR_ALT_CTRL}, 8'h00);
    check("g oe_n off", {27'h0, pg_oe_n}, 32'h15);
    check("g pull off", {27'h0, pg_pullup}, 32'h1f);
    $display("test port g done");
  endtask : t_pg

  // Port C registers left untouched in legacy mode
  task automatic t_compat;
    @(posedge clk);
    compat_mode <= 1'b1;
    reset_n     <= 1'b0;
    #1;
    // Checked before any clock edge inside reset
    check("c oe_n", {24'h0, poe_n[2]}, 32'h0);
    check("c out", {24'h0, po[2]}, 32'h0);
    check("g oe_n", {27'h0, pg_oe_n}, 32'h18);
    check("xtal", {31'h0, xtal_amp_en}, 32'h1);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    check("c oe_n", {24'h0, poe_n[2]}, 32'h0);
    check("a oe_n", {24'h0, poe_n[0]}, 32'hff);
    check("g pull", {27'h0, pg_pullup}, 32'h0);
    rchk("a latch", ra(0, pga_pkg::OFF_LATCH), 32'h0, 1'b0);
    $display("test legacy done");
  endtask : t_compat

  // ==========================================================
  // Main sequence
  initial
  begin
    reset_n      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 32'h0;
    pwdata       = 32'h0;
    pstrb        = 4'h0;
    compat_mode  = 1'b0;
    ext_en       = 8'hff;
    ext          = 8'h00;
    pg_base_out  = 5'h00;
    pg_base_dir  = 5'h00;
    pg_base_pull = 5'h00;
    ale          = 1'b0;
    rd_n         = 1'b1;
    wr_n         = 1'b1;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_rw();
    t_pg();
    t_compat();
    report_and_stop();
  end
endmodule : test_port_g_altfunc_and_port_regs

// ### verilog/pga_pin_ovr.sv
// One pin's alternate-function override multiplexer
`timescale 1ns/1ps
module pga_pin_ovr
(
  input  wire logic base_pull,
  input  wire logic base_dir,
  input  wire logic base_out,
  input  wire logic base_in_en,
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic dir_override_en,
  input  wire logic dir_override_val,
  input  wire logic outval_override_en,
  input  wire logic outval_override_val,
  input  wire logic input_en_override_en,
  input  wire logic input_en_override_val,
  output wire logic pin_pull,
  output wire logic pin_dir,
  output wire logic pin_out,
  output wire logic pin_in_en
);

  // ==========================================================
  // Override selection
  // Purely combinational so an enable change acts at once
  assign pin_pull  = pullup_override_en ? pullup_override_val
                                        : base_pull;
  assign pin_dir   = dir_override_en ? dir_override_val : base_dir;
  assign pin_out   = outval_override_en ? outval_override_val : base_out;
  assign pin_in_en = input_en_override_en ? input_en_override_val
                                          : base_in_en;

endmodule : pga_pin_ovr

// ### verilog/pga_port_top.sv
// Port A-D registers over APB and port G alternate-function overrides
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module pga_port_top
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        compat_mode,
  input  wire logic [7:0]  pa_in,
  output wire logic [7:0]  pa_out,
  output wire logic [7:0]  pa_oe_n,
  output wire logic [7:0]  pa_pullup,
  input  wire logic [7:0]  pb_in,
  output wire logic [7:0]  pb_out,
  output wire logic [7:0]  pb_oe_n,
  output wire logic [7:0]  pb_pullup,
  input  wire logic [7:0]  pc_in,
  output wire logic [7:0]  pc_out,
  output wire logic [7:0]  pc_oe_n,
  output wire logic [7:0]  pc_pullup,
  input  wire logic [7:0]  pd_in,
  output wire logic [7:0]  pd_out,
  output wire logic [7:0]  pd_oe_n,
  output wire logic [7:0]  pd_pullup,
  input  wire logic [4:0]  pg_base_out,
  input  wire logic [4:0]  pg_base_dir,
  input  wire logic [4:0]  pg_base_pull,
  input  wire logic        ext_mem_ale,
  input  wire logic        ext_mem_rd_n,
  input  wire logic        ext_mem_wr_n,
  output wire logic [4:0]  pg_out,
  output wire logic [4:0]  pg_oe_n,
  output wire logic [4:0]  pg_pullup,
  output wire logic [4:0]  pg_in_en,
  output wire logic        xtal_amp_en
);

  // ==========================================================
  // Storage
  logic [7:0] latch_q [pga_pkg::NBANKS];
  logic [7:0] dir_q   [pga_pkg::NBANKS];
  logic [7:0] sense_q [pga_pkg::NBANKS];
  logic [1:0] ctrl_q;
  logic       legacy_hold_q;
  logic [31:0] prdata_q;

  // ==========================================================
  // APB decode
  wire        setup_ph  = psel & ~penable;
  wire        access_ph = psel & penable;
  wire        hi_zero   = (paddr[31:8] == 24'h000000);
  wire [1:0]  bank_sel  = paddr[pga_pkg::BANK_LSB +: 2];
  wire [1:0]  fld_sel   = paddr[pga_pkg::FIELD_LSB +: 2];
  wire        low_zero  = (paddr[1:0] == 2'h0);
  wire        bank_area = hi_zero & low_zero & ~paddr[7] & ~paddr[6];
  wire        bank_hit  = bank_area & (fld_sel != 2'h3);
  wire        ctrl_hit  = hi_zero &
                          (paddr[7:0] == pga_pkg::ADDR_ALT_CTRL);
  wire        addr_hit  = bank_hit | ctrl_hit;
  wire        wr_fire   = access_ph & pwrite & addr_hit & pstrb[0];
  wire        wr_latch  = wr_fire & bank_hit &
                          (fld_sel == pga_pkg::FLD_LATCH);
  wire        wr_dir    = wr_fire & bank_hit &
                          (fld_sel == pga_pkg::FLD_DIR);
  wire        wr_ctrl   = wr_fire & ctrl_hit;
  wire        wr_c_dir  = wr_dir & (bank_sel == pga_pkg::BANK_C_IDX);

  // Zero wait states; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_hit;
  assign prdata  = prdata_q;

  // ==========================================================
  // Effective direction and pin inputs
  logic [7:0] dir_eff [pga_pkg::NBANKS];
  logic [7:0] pin_in  [pga_pkg::NBANKS];

  assign pin_in[0] = pa_in;
  assign pin_in[1] = pb_in;
  assign pin_in[2] = pc_in;
  assign pin_in[3] = pd_in;

  assign dir_eff[0] = dir_q[0];
  assign dir_eff[1] = dir_q[1];
  // Hold comes from async reset, so needs no clock edge
  assign dir_eff[2] = (compat_mode & legacy_hold_q) ?
                      pga_pkg::LEGACY_C_DIR : dir_q[2];
  assign dir_eff[3] = dir_q[3];

  // ==========================================================
  // Read multiplexer
  wire [7:0] rd_bank =
    (fld_sel == pga_pkg::FLD_LATCH) ? latch_q[bank_sel] :
    (fld_sel == pga_pkg::FLD_DIR)   ? dir_eff[bank_sel] :
                                      sense_q[bank_sel];
  wire [31:0] rd_mux =
    bank_hit ? {24'h000000, rd_bank} :
    ctrl_hit ? {30'h00000000, ctrl_q} : 32'h00000000;

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (setup_ph && !pwrite)
    begin
      prdata_q <= rd_mux;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < pga_pkg::NBANKS; gb++)
    begin : g_bank
      wire sel_b = (bank_sel == 2'(gb));
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          latch_q[gb] <= pga_pkg::LATCH_RST;
          dir_q[gb]   <= pga_pkg::DIR_RST;
          sense_q[gb] <= pga_pkg::SENSE_RST;
        end
        else
        begin
          if (wr_latch && sel_b)
            latch_q[gb] <= pwdata[7:0];
          if (wr_dir && sel_b)
            dir_q[gb] <= pwdata[7:0];
          sense_q[gb] <= pin_in[gb];
        end
      end
    end
  endgenerate

  // Legacy port C hold ends at the first port C direction write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      legacy_hold_q <= 1'b1;
      ctrl_q        <= pga_pkg::CTRL_RST;
    end
    else
    begin
      if (wr_c_dir)
        legacy_hold_q <= 1'b0;
      if (wr_ctrl)
        ctrl_q <= pwdata[1:0];
    end
  end

  // ==========================================================
  // Port A-D pins
  // Pull-up only on inputs whose latch bit is one
  assign pa_out    = latch_q[0];
  assign pa_oe_n   = ~dir_eff[0];
  assign pa_pullup = ~dir_eff[0] & latch_q[0];
  assign pb_out    = latch_q[1];
  assign pb_oe_n   = ~dir_eff[1];
  assign pb_pullup = ~dir_eff[1] & latch_q[1];
  assign pc_out    = latch_q[2];
  assign pc_oe_n   = ~dir_eff[2];
  assign pc_pullup = ~dir_eff[2] & latch_q[2];
  assign pd_out    = latch_q[3];
  assign pd_oe_n   = ~dir_eff[3];
  assign pd_pullup = ~dir_eff[3] & latch_q[3];

  // ==========================================================
  // Port G override enables and values
  wire async_eff  = ctrl_q[pga_pkg::CTRL_ASYNC_BIT] | compat_mode;
  wire extmem_eff = ctrl_q[pga_pkg::CTRL_EXTMEM_BIT] | compat_mode;

  logic [4:0] pu_en;
  logic [4:0] dir_en;
  logic [4:0] dir_val;
  logic [4:0] out_en;
  logic [4:0] out_val;
  logic [4:0] die_en;
  logic [4:0] pg_dir;

  // Crystal pins keep the port value; only controls are forced
  assign pu_en   = {async_eff, async_eff, {3{extmem_eff}}};
  assign dir_en  = {async_eff, async_eff, {3{extmem_eff}}};
  assign dir_val = 5'h07;
  assign out_en  = {2'h0, {3{extmem_eff}}};
  assign out_val = {2'h0, ext_mem_ale, ext_mem_rd_n,
                    ext_mem_wr_n};
  assign die_en  = {async_eff, async_eff, 3'h0};

  genvar gp;
  generate
    for (gp = 0; gp < pga_pkg::PG_W; gp++)
    begin : g_pin
      pga_pin_ovr u_ovr
      (
        .base_pull             (pg_base_pull[gp]),
        .base_dir              (pg_base_dir[gp]),
        .base_out              (pg_base_out[gp]),
        .base_in_en            (1'b1),
        .pullup_override_en    (pu_en[gp]),
        .pullup_override_val   (1'b0),
        .dir_override_en       (dir_en[gp]),
        .dir_override_val      (dir_val[gp]),
        .outval_override_en    (out_en[gp]),
        .outval_override_val   (out_val[gp]),
        .input_en_override_en  (die_en[gp]),
        .input_en_override_val (1'b0),
        .pin_pull              (pg_pullup[gp]),
        .pin_dir               (pg_dir[gp]),
        .pin_out               (pg_out[gp]),
        .pin_in_en             (pg_in_en[gp])
      );
    end
  endgenerate

  assign pg_oe_n     = ~pg_dir;
  assign xtal_amp_en = async_eff;

  // ==========================================================
  // Checks
  legacy_g_alt_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    compat_mode |-> (pg_oe_n == 5'h18) && xtal_amp_en)
    else $error("legacy mode left port G as general I/O");

  xtal_in_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    async_eff |-> pg_oe_n[4] && !pg_pullup[4] && !pg_in_en[4])
    else $error("crystal input pin not detached");

  xtal_out_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    async_eff |-> pg_oe_n[3] && !pg_pullup[3] && !pg_in_en[3])
    else $error("crystal output pin not detached");

  xtal_value_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    async_eff |-> pg_out[4:3] == pg_base_out[4:3])
    else $error("crystal pin output value was overridden");

  ale_drive_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    extmem_eff |-> !pg_oe_n[2] && !pg_pullup[2] &&
                   pg_out[2] == ext_mem_ale)
    else $error("latch strobe pin not driven");

  rd_drive_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    extmem_eff |-> !pg_oe_n[1] && !pg_pullup[1] &&
                   pg_out[1] == ext_mem_rd_n)
    else $error("read strobe pin not driven");

  wr_drive_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    extmem_eff |-> !pg_oe_n[0] && !pg_pullup[0] &&
                   pg_out[0] == ext_mem_wr_n && pg_in_en[0])
    else $error("write strobe pin wrong");

  latch_store_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_latch && bank_sel == 2'h0) |=>
      pa_out == $past(pwdata[7:0]))
    else $error("latch write not seen on pins");

  dir_store_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_dir && bank_sel == 2'h1) |=>
      pb_oe_n == ~$past(pwdata[7:0]))
    else $error("direction write not seen on pins");

  sense_follow_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(reset_n) |-> sense_q[3] == $past(pd_in))
    else $error("pin sense does not follow pins");

  legacy_c_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ($rose(reset_n) && compat_mode) |->
      pc_oe_n == 8'h00 && pc_out == 8'h00)
    else $error("legacy port C not push-pull zero");

  ctrl_effect_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_ctrl && pwdata[1]) |=> !pg_oe_n[2] && !pg_oe_n[0])
    else $error("memory enable did not take effect");

endmodule : pga_port_top
